// ===== ddsl_top.sv
// Dual video input skew compensation with link and clock status bank.
// Assumes status inputs are asynchronous levels from neighbouring blocks,
// video inputs share clk, and a classic Wishbone master on clk.
//
// Register access over Wishbone is this design's own decision.
`include "ddsl_defs.svh"

module ddsl_top #(
	parameter int DW = 24
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [9:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [DW-1:0] vid0_i,
	input wire logic vid0_de_i,
	input wire logic [DW-1:0] vid1_i,
	input wire logic vid1_de_i,
	output logic [DW-1:0] vid0_o,
	output logic vid0_de_o,
	output logic [DW-1:0] vid1_o,
	output logic vid1_de_o,
	input wire logic indep_mode_i,
	input wire logic port_sel_i,
	input wire logic [1:0] link_found_i,
	input wire logic [1:0] caps_known_i,
	input wire logic [1:0] tx_active_i,
	input wire logic [1:0] rx_locked_i,
	input wire logic [1:0] video_valid_i,
	input wire logic [1:0] mode_entered_i,
	input wire ddsl_pkg::ddsl_mode_t output_port_mode_i,
	input wire logic [1:0] clk_det_i,
	input wire logic [1:0] pll_lock_i,
	input wire logic [1:0] below_low_frequency_threshold_i,
	input wire logic [1:0] input_frequency_stable_i,
	output logic irq_o
);
	import ddsl_pkg::*;

	// -------------------------------------------------------------------
	// State
	// -------------------------------------------------------------------
	localparam int NS = 15;
	typedef struct packed {
		logic [31:0] dat;
		logic ack;
		logic [1:0] second_port_input_delay;
		logic [1:0] first_port_input_delay;
		logic force_ready;
		logic override_clock_present;
		logic [3:0] irq_sts;
		logic [3:0] irq_mask;
		logic irq;
		logic [2:0][DW:0] p0_pipe;
		logic [2:0][DW:0] p1_pipe;
		logic [DW:0] v0_out;
		logic [DW:0] v1_out;
		logic [2:0] skew_cnt;
		logic counting;
		logic who_first;
		logic dual_ok;
		logic skew_sign;
		logic [1:0] skew_magnitude;
		logic [7:0] link_sts;
		logic [1:0] de_prev;
		logic [1:0][NS-1:0] s1;
		logic [1:0][NS-1:0] s2;
	} ddsl_state_t;

	ddsl_state_t st_r;
	ddsl_state_t st_nxt;

	// Picks one bit of a per-port pair by the reporting port
	function automatic logic pick(input logic [1:0] v, input logic sel);
		pick = sel ? v[1] : v[0];
	endfunction : pick

	// Delay selection: n stages behind the input, zero means straight
	function automatic logic [DW:0] tap(input logic [DW:0] in_v,
		input logic [2:0][DW:0] pipe, input logic [1:0] n);
		case (n)
			2'd0: tap = in_v;
			2'd1: tap = pipe[0];
			2'd2: tap = pipe[1];
			2'd3: tap = pipe[2];
			default: tap = in_v;
		endcase
	endfunction : tap

	logic [NS-1:0] raw0;
	logic [NS-1:0] raw1;
	logic [NS-1:0] syn0;
	logic [NS-1:0] syn1;
	logic [9:0] idx;
	logic [7:0] rd_byte;
	logic sel_port;
	logic bus_req;
	logic wr_en;
	logic [7:0] wb_b;

	// -------------------------------------------------------------------
	// Asynchronous status levels, packed per port for synchronising
	// -------------------------------------------------------------------
	assign raw0 = {indep_mode_i, port_sel_i, link_found_i[0],
		caps_known_i[0], tx_active_i[0], rx_locked_i[0], video_valid_i[0],
		mode_entered_i[0], output_port_mode_i, clk_det_i[0], pll_lock_i[0],
		below_low_frequency_threshold_i[0], input_frequency_stable_i[0],
		1'b0};
	assign raw1 = {indep_mode_i, port_sel_i, link_found_i[1],
		caps_known_i[1], tx_active_i[1], rx_locked_i[1], video_valid_i[1],
		mode_entered_i[1], output_port_mode_i, clk_det_i[1], pll_lock_i[1],
		below_low_frequency_threshold_i[1], input_frequency_stable_i[1],
		1'b0};
	assign syn0 = st_r.s2[0];
	assign syn1 = st_r.s2[1];
	// Only independent mode follows the selector; otherwise port 0 reports
	assign sel_port = syn0[14] & syn0[13];
	assign idx = wb_adr_i >> 2;
	assign bus_req = wb_cyc_i & wb_stb_i & ~st_r.ack;
	assign wr_en = bus_req & wb_we_i & wb_sel_i[0];
	assign wb_b = wb_dat_i[7:0];

	// -------------------------------------------------------------------
	// Read multiplexer; unmapped words read zero but still acknowledge
	// -------------------------------------------------------------------
	always_comb begin
		case (idx)
			10'(`DDSL_IDX_DELAY_SKEW): rd_byte = {st_r.second_port_input_delay,
				st_r.first_port_input_delay, st_r.dual_ok, st_r.skew_sign,
				st_r.skew_magnitude};
			10'(`DDSL_IDX_LINK_STS): rd_byte = st_r.link_sts;
			10'(`DDSL_IDX_CTRL): rd_byte = {6'h00, st_r.override_clock_present,
				st_r.force_ready};
			10'(`DDSL_IDX_IRQ_STS): rd_byte = {4'h0, st_r.irq_sts};
			10'(`DDSL_IDX_IRQ_MASK): rd_byte = {4'h0, st_r.irq_mask};
			default: rd_byte = 8'h00;
		endcase
	end

	// -------------------------------------------------------------------
	// Next-state logic
	// -------------------------------------------------------------------
	always_comb begin
		logic [DW:0] in0;
		logic [DW:0] in1;
		logic lr;
		logic tx;
		logic cd;
		logic [7:0] ls;
		logic [3:0] ev;
		logic rise0;
		logic rise1;
		in0 = {vid0_de_i, vid0_i};
		in1 = {vid1_de_i, vid1_i};
		st_nxt = st_r;
		lr = 1'b0;
		tx = 1'b0;
		cd = 1'b0;
		ls = 8'h00;
		ev = 4'h0;
		rise0 = 1'b0;
		rise1 = 1'b0;

		// Two-flop synchronisers; only the second stage is read
		st_nxt.s1[0] = raw0;
		st_nxt.s1[1] = raw1;
		st_nxt.s2 = st_r.s1;

		// Bus answer: one cycle after the request, dropped the cycle after
		st_nxt.ack = bus_req;
		st_nxt.dat = {24'h000000, rd_byte};
		if (wr_en) begin
			case (idx)
				10'(`DDSL_IDX_DELAY_SKEW): begin
					st_nxt.second_port_input_delay =
						wb_b[`DDSL_P1_DLY_HI:`DDSL_P1_DLY_LO];
					st_nxt.first_port_input_delay =
						wb_b[`DDSL_P0_DLY_HI:`DDSL_P0_DLY_LO];
				end
				10'(`DDSL_IDX_CTRL): begin
					st_nxt.force_ready = wb_b[0];
					st_nxt.override_clock_present = wb_b[1];
				end
				10'(`DDSL_IDX_IRQ_MASK): st_nxt.irq_mask = wb_b[3:0];
				default: ;
			endcase
		end

		// Delay lines: a value n taps the n-th stage
		st_nxt.p0_pipe = {st_r.p0_pipe[1:0], in0};
		st_nxt.p1_pipe = {st_r.p1_pipe[1:0], in1};
		st_nxt.v0_out = tap(in0, st_r.p0_pipe,
			st_r.first_port_input_delay);
		st_nxt.v1_out = tap(in1, st_r.p1_pipe,
			st_r.second_port_input_delay);

		// Skew measurement between line-start edges of the raw inputs
		st_nxt.de_prev = {vid1_de_i, vid0_de_i};
		rise0 = vid0_de_i & ~st_r.de_prev[0];
		rise1 = vid1_de_i & ~st_r.de_prev[1];
		if (rise0 & rise1) begin
			st_nxt.counting = 1'b0;
			st_nxt.dual_ok = 1'b1;
			st_nxt.skew_sign = 1'b0;
			st_nxt.skew_magnitude = 2'd0;
		end else if (!st_r.counting && (rise0 || rise1)) begin
			st_nxt.counting = 1'b1;
			st_nxt.who_first = rise1;
			st_nxt.skew_cnt = 3'd1;
		end else if (st_r.counting) begin
			if ((st_r.who_first && rise0) || (!st_r.who_first && rise1)) begin
				st_nxt.counting = 1'b0;
				st_nxt.dual_ok = 1'b1;
				st_nxt.skew_sign = st_r.who_first;
				st_nxt.skew_magnitude = st_r.skew_cnt[1:0];
			end else if (st_r.skew_cnt == 3'(`DDSL_SKEW_MAX)) begin
				// Beyond measurable range: health drops
				st_nxt.counting = 1'b0;
				st_nxt.dual_ok = 1'b0;
			end else begin
				st_nxt.skew_cnt = st_r.skew_cnt + 3'd1;
			end
		end
		// Health needs both inputs active
		if (!(syn0[8] & syn1[8]))
			st_nxt.dual_ok = 1'b0;

		// Link and clock status for the reporting port
		lr = (pick({syn1[12], syn0[12]}, sel_port) &
			pick({syn1[11], syn0[11]}, sel_port)) | st_r.force_ready;
		tx = pick({syn1[10], syn0[10]}, sel_port) &
			pick({syn1[9], syn0[9]}, sel_port) &
			pick({syn1[8], syn0[8]}, sel_port) &
			pick({syn1[7], syn0[7]}, sel_port);
		cd = pick({syn1[4], syn0[4]}, sel_port) |
			st_r.override_clock_present;
		ls[7] = lr;
		ls[6] = tx;
		ls[5:4] = tx ? syn0[6:5] : 2'b00;
		ls[3] = cd;
		ls[2] = pick({syn1[3], syn0[3]}, sel_port);
		ls[1] = pick({syn1[2], syn0[2]}, sel_port);
		ls[0] = pick({syn1[1], syn0[1]}, sel_port);
		st_nxt.link_sts = ls;

		// Events: rises of ready, transmit, health and falls of lock
		ev[0] = ls[7] & ~st_r.link_sts[7];
		ev[1] = ls[6] & ~st_r.link_sts[6];
		ev[2] = st_nxt.dual_ok & ~st_r.dual_ok;
		ev[3] = ~ls[2] & st_r.link_sts[2];
		// Set wins over write-one-to-clear in the same cycle
		st_nxt.irq_sts = ev | (st_r.irq_sts &
			~((wr_en && idx == 10'(`DDSL_IDX_IRQ_STS)) ? wb_b[3:0] : 4'h0));
		st_nxt.irq = |(st_nxt.irq_sts & st_nxt.irq_mask);

		if (!rst_n)
			st_nxt = '0;
	end

	// -------------------------------------------------------------------
	// State register
	// -------------------------------------------------------------------
	always_ff @(posedge clk) begin
		st_r <= st_nxt;
	end

	assign wb_dat_o = st_r.dat;
	assign wb_ack_o = st_r.ack;
	assign vid0_o = st_r.v0_out[DW-1:0];
	assign vid0_de_o = st_r.v0_out[DW];
	assign vid1_o = st_r.v1_out[DW-1:0];
	assign vid1_de_o = st_r.v1_out[DW];
	assign irq_o = st_r.irq;

	// -------------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------------
	// Helpers for the checks below, named so the properties stay short
	logic rise_both;
	logic tx_ok;
	assign rise_both = vid0_de_i & ~st_r.de_prev[0] & vid1_de_i &
		~st_r.de_prev[1];
	assign tx_ok = pick({syn1[10], syn0[10]}, sel_port) &
		pick({syn1[8], syn0[8]}, sel_port);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_req;
		bus_req ##1 1'b1;
	endsequence

	// Rise and fall patterns behind the event and health checks
	sequence s_ready_rise;
		!st_r.link_sts[7] ##1 st_r.link_sts[7];
	endsequence

	sequence s_lock_fall;
		st_r.link_sts[2] ##1 !st_r.link_sts[2];
	endsequence

	sequence s_health_rise;
		!st_r.dual_ok ##1 st_r.dual_ok;
	endsequence

	// Software-written delay fields land on the next edge
	a_second_delay: assert property (
		wr_en && idx == 10'(`DDSL_IDX_DELAY_SKEW) |=>
		st_r.second_port_input_delay == $past(wb_dat_i[7:6]))
		else $error("second delay not stored");
	a_first_delay: assert property (
		wr_en && idx == 10'(`DDSL_IDX_DELAY_SKEW) |=>
		st_r.first_port_input_delay == $past(wb_dat_i[5:4]))
		else $error("first delay not stored");

	// Delay taps: zero is a straight register, n adds n stages
	a_delay_exact: assert property (
		(st_r.first_port_input_delay == 2'd2 &&
		$stable(st_r.first_port_input_delay)) [*3] |=>
		vid0_o == $past(vid0_i, 3))
		else $error("delay stages wrong");
	a_zero_pass: assert property (
		rst_n && st_r.first_port_input_delay == 2'd0 |=>
		{vid0_de_o, vid0_o} == $past({vid0_de_i, vid0_i}))
		else $error("zero delay not straight");
	a_second_stage: assert property (
		(st_r.second_port_input_delay == 2'd1 &&
		$stable(st_r.second_port_input_delay)) [*2] |=>
		{vid1_de_o, vid1_o} == $past({vid1_de_i, vid1_i}, 2))
		else $error("second delay stage wrong");

	// Health and skew fields
	a_health_need: assert property (
		!(syn0[8] & syn1[8]) |=> !st_r.dual_ok)
		else $error("health with inactive input");
	a_health_rise: assert property (
		s_health_rise |-> $past(syn0[8] & syn1[8]))
		else $error("health rose without both inputs");
	a_sign_zero: assert property (
		rise_both |=> !st_r.skew_sign && st_r.skew_magnitude == 2'd0)
		else $error("zero skew wrong");
	a_skew_bound: assert property (
		st_r.counting |-> st_r.skew_cnt != 3'd0 &&
		st_r.skew_cnt <= 3'(`DDSL_SKEW_MAX))
		else $error("skew count out of range");

	// Link and clock status; the mode field only shows while transmitting
	a_ready_force: assert property (
		st_r.force_ready |=> st_r.link_sts[7])
		else $error("forced ready missing");
	a_tx_needs: assert property (
		st_r.link_sts[6] |-> $past(tx_ok))
		else $error("transmit without causes");
	a_mode_zero: assert property (
		!st_r.link_sts[6] |-> st_r.link_sts[5:4] == 2'b00)
		else $error("mode shown idle");
	a_mode_show: assert property (
		st_r.link_sts[6] |-> st_r.link_sts[5:4] == $past(syn0[6:5]))
		else $error("mode field not passed through");
	a_clk_force: assert property (
		st_r.override_clock_present |=> st_r.link_sts[3])
		else $error("clock override ignored");

	// Bus answer and sticky events; a set must beat a same-cycle clear
	a_ack_once: assert property (s_req |-> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not single cycle");
	a_ready_event: assert property (s_ready_rise |-> st_r.irq_sts[0])
		else $error("ready rise not latched");
	a_lock_event: assert property (s_lock_fall |-> st_r.irq_sts[3])
		else $error("lock fall not latched");
endmodule : ddsl_top

// ===== ddsl_defs.svh
// Register offsets, field positions, reset values for the dual-input
// skew/link status bank. Assumes inclusion by the design top and bench.
`ifndef DDSL_DEFS_SVH
`define DDSL_DEFS_SVH
// -----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// -----------------------------------------------------------------------
`define DDSL_IDX_DELAY_SKEW 8'h59
`define DDSL_IDX_LINK_STS 8'h5A
`define DDSL_IDX_CTRL 8'h60
`define DDSL_IDX_IRQ_STS 8'h61
`define DDSL_IDX_IRQ_MASK 8'h62
// -----------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------
`define DDSL_P1_DLY_HI 7
`define DDSL_P1_DLY_LO 6
`define DDSL_P0_DLY_HI 5
`define DDSL_P0_DLY_LO 4
`define DDSL_DUAL_OK_BIT 3
`define DDSL_SIGN_BIT 2
`define DDSL_MODE_DUAL 2'h0
`define DDSL_MODE_SINGLE0 2'h1
`define DDSL_MODE_SINGLE1 2'h2
`define DDSL_MODE_BOTH 2'h3
`define DDSL_REG_RESET 8'h00
`define DDSL_SKEW_MAX 3
`define DDSL_IRQ_BITS 4
`endif

// ===== ddsl_pkg.sv
// Types shared by the dual-input skew/link status bank.
// Assumes the defs header sits alongside it.
package ddsl_pkg;
	// Output port operating mode, as reported to software
	typedef enum logic [1:0] {
		DDSL_DUAL = 2'b00,
		DDSL_SINGLE0 = 2'b01,
		DDSL_SINGLE1 = 2'b10,
		DDSL_BOTH = 2'b11
	} ddsl_mode_t;
endpackage : ddsl_pkg

// ===== ddsl_src_model.sv
// Two-port video source model: each port carries a running pixel count.
// Assumes the bench sets the port-1 lag; DE is high 12 of every 32 pixels.
module ddsl_src_model #(
	parameter int DW = 24
) (
	input wire logic clk,
	input wire logic signed [3:0] lag,
	output logic [DW-1:0] vid0,
	output logic de0,
	output logic [DW-1:0] vid1,
	output logic de1
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [DW-1:0] cnt_r = '0;
	// Free-running count, so any delay shows as a plain offset
	always @(posedge clk) begin
		cnt_r <= cnt_r + 1'b1;
	end
	// Port 1 trails by lag clocks; a negative lag makes it lead
	assign vid0 = cnt_r;
	assign vid1 = cnt_r - DW'(lag);
	assign de0 = vid0[4:0] < 5'd12;
	assign de1 = vid1[4:0] < 5'd12;
endmodule : ddsl_src_model

// ===== ddsl_tb.sv
// Bench for the dual-input skew and link status bank.
// Assumes a one-cycle Wishbone answer and the video source model.
`include "ddsl_defs.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ddsl_pkg::*;
	localparam int DW = 24;
	logic clk = 0;
	logic rst_n = 0;
	logic [9:0] adr = '0;
	logic [31:0] wd = '0;
	logic we = 0;
	logic cyc = 0;
	logic [31:0] rdat;
	logic ack, irq, d0, d1, d0o, d1o;
	logic [DW-1:0] v0, v1, v0o, v1o, e0, e1;
	logic signed [3:0] lag = 0;
	logic ind = 0;
	logic psel = 0;
	logic [1:0] lf = 0, ck = 0, txa = 0, rxl = 0, vv = 0, me = 0;
	logic [1:0] cd = 0, pl = 0, lo = 0, st = 0;
	ddsl_mode_t pm = DDSL_DUAL;
	logic [7:0] r;
	logic signed [3:0] lags [4] = '{4'sd2, -4'sd3, 4'sd0, 4'sd5};
	logic [7:0] sk_e [4] = '{8'h0A, 8'h0F, 8'h08, 8'h00};
	logic [7:0] sk_m [4] = '{8'hFF, 8'hFF, 8'hFF, 8'h08};
	logic [7:0] regs [6] = '{8'h59, 8'h5A, 8'h60, 8'h61, 8'h62, 8'h10};
	int error_cnt = 0;
	int n_compared = 0;
	// -------------------------------------------------------------------
	// Design and source
	// -------------------------------------------------------------------
	ddsl_src_model #(.DW(DW)) u_ddsl_src_model (.clk(clk), .lag(lag),
		.vid0(v0), .de0(d0), .vid1(v1), .de1(d1));
	ddsl_top #(.DW(DW)) u_ddsl_top (.clk(clk), .rst_n(rst_n),
		.wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(4'h1), .wb_we_i(we),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rdat), .wb_ack_o(ack),
		.vid0_i(v0), .vid0_de_i(d0), .vid1_i(v1), .vid1_de_i(d1),
		.vid0_o(v0o), .vid0_de_o(d0o), .vid1_o(v1o), .vid1_de_o(d1o),
		.indep_mode_i(ind), .port_sel_i(psel), .link_found_i(lf),
		.caps_known_i(ck), .tx_active_i(txa), .rx_locked_i(rxl),
		.video_valid_i(vv), .mode_entered_i(me), .output_port_mode_i(pm),
		.clk_det_i(cd), .pll_lock_i(pl),
		.below_low_frequency_threshold_i(lo),
		.input_frequency_stable_i(st), .irq_o(irq));
	// -------------------------------------------------------------------
	// Tasks
	// -------------------------------------------------------------------
	task automatic final_report;
		$display("compared %0d mismatched %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// One classic cycle; ack and data are sampled at rising edges only
	task automatic xfer(input logic w, input logic [7:0] idx,
		input logic [7:0] d, output logic [7:0] q);
		int i;
		@(posedge clk);
		adr <= {idx, 2'b00};
		wd <= {24'h0, d};
		we <= w;
		cyc <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (ack === 1'b1)
				break;
		end
		if (i == 20) begin
			error_cnt++;
			$display("[ERR] %0t no answer", $time);
			final_report();
		end
		q = rdat[7:0];
		// Released right at the edge that saw ack
		cyc <= 1'b0;
		we <= 1'b0;
	endtask : xfer
	task automatic rdc(input logic [7:0] idx, msk, exp);
		xfer(1'b0, idx, 8'h00, r);
		chk(r & msk, exp);
	endtask : rdc
	task automatic settle(input int k);
		repeat (k) @(posedge clk);
	endtask : settle
	// -------------------------------------------------------------------
	// Clock and tests
	// -------------------------------------------------------------------
	initial begin
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		// Writes to a status register must not stick
		xfer(1'b1, `DDSL_IDX_LINK_STS, 8'hFF, r);
		foreach (regs[i]) rdc(regs[i], 8'hFF, 8'h00);
		$display("reset test done");
		// Every delay value on both ports, latency is 1 + n
		for (int n = 0; n < 4; n++) begin
			xfer(1'b1, `DDSL_IDX_DELAY_SKEW, {2'(3 - n), 2'(n), 4'hF}, r);
			rdc(`DDSL_IDX_DELAY_SKEW, 8'hF0, {2'(3 - n), 2'(n), 4'h0});
			settle(6);
			e0 = v0 - DW'(1 + n);
			e1 = v1 - DW'(4 - n);
			chk({d0o, v0o[6:0]}, {e0[4:0] < 5'd12, e0[6:0]});
			chk({d1o, v1o[6:0]}, {e1[4:0] < 5'd12, e1[6:0]});
		end
		xfer(1'b1, `DDSL_IDX_DELAY_SKEW, 8'h00, r);
		$display("delay test done");
		vv <= 2'b11;
		for (int i = 0; i < 4; i++) begin
			lag <= lags[i];
			settle(70);
			rdc(`DDSL_IDX_DELAY_SKEW, sk_m[i], sk_e[i]);
			chk(r & 8'h03, sk_e[i] & 8'h03);
		end
		vv <= 2'b01;
		lag <= 4'sd1;
		settle(70);
		rdc(`DDSL_IDX_DELAY_SKEW, 8'h08, 8'h00);
		$display("skew test done");
		lf <= 2'b01;
		settle(5);
		rdc(`DDSL_IDX_LINK_STS, 8'hFF, 8'h00);
		ck <= 2'b01;
		txa <= 2'b01;
		rxl <= 2'b01;
		settle(5);
		rdc(`DDSL_IDX_LINK_STS, 8'hFF, 8'h80);
		me <= 2'b01;
		for (int m = 0; m < 4; m++) begin
			pm <= ddsl_mode_t'(m);
			settle(5);
			rdc(`DDSL_IDX_LINK_STS, 8'hFF, {2'b11, 2'(m), 4'h0});
		end
		rxl <= 2'b00;
		cd <= 2'b01;
		pl <= 2'b10;
		lo <= 2'b01;
		st <= 2'b10;
		settle(5);
		rdc(`DDSL_IDX_LINK_STS, 8'hFF, 8'h8A);
		ind <= 1'b1;
		psel <= 1'b1;
		settle(5);
		rdc(`DDSL_IDX_LINK_STS, 8'hFF, 8'h05);
		xfer(1'b1, `DDSL_IDX_CTRL, 8'h02, r);
		rdc(`DDSL_IDX_LINK_STS, 8'h0F, 8'h0D);
		xfer(1'b1, `DDSL_IDX_CTRL, 8'h03, r);
		rdc(`DDSL_IDX_LINK_STS, 8'hFF, 8'h8D);
		xfer(1'b1, `DDSL_IDX_CTRL, 8'h00, r);
		ind <= 1'b0;
		lf <= 2'b00;
		settle(5);
		rdc(`DDSL_IDX_LINK_STS, 8'hFF, 8'h0A);
		$display("status test done");
		// Sticky event, masked, unmasked, then one-to-clear
		xfer(1'b1, `DDSL_IDX_IRQ_STS, 8'hFF, r);
		rdc(`DDSL_IDX_IRQ_STS, 8'hFF, 8'h00);
		lf <= 2'b01;
		settle(5);
		rdc(`DDSL_IDX_IRQ_STS, 8'h01, 8'h01);
		chk({7'h0, irq}, 8'h00);
		xfer(1'b1, `DDSL_IDX_IRQ_MASK, 8'h01, r);
		xfer(1'b1, `DDSL_IDX_IRQ_STS, 8'h00, r);
		settle(3);
		chk({7'h0, irq}, 8'h01);
		xfer(1'b1, `DDSL_IDX_IRQ_STS, 8'h01, r);
		settle(3);
		chk({7'h0, irq}, 8'h00);
		rdc(`DDSL_IDX_IRQ_MASK, 8'hFF, 8'h01);
		$display("interrupt test done");
		final_report();
	end
endmodule : tb
